// ### verilog/rgi2c_port.sv
// Function
// R1: answer only target address 0x70, byte 0xE0 with write bit low.
// R2: sample data on SCL rise; change SDA only while SCL is low.
// R3: transactions start from idle with a START, SDA falling while SCL high.
// R4: STOP, SDA rising while SCL high, returns the port to idle matching.
// R5: reads send register address, repeated start, then address with read bit.
// R6: master code 00001XXX after START is never acknowledged.
// R7: repeated start after the master code enters high-speed mode.
// R8: high-speed mode lasts until STOP; packets split by repeated starts.
// R9: every byte moves most significant bit first.
// R10: acknowledge by pulling SDA low in ninth clock; release for not-acknowledge.
// R11: register 0x01 holds 7-bit target code, bit 7 reserved, resets zero.
// R12: host never writes reserved target codes such as 0x00.
// R13: register 0x02 bit 3 selects bypass when set, resets zero.
// R14: register 0x02 bit 2 forces fixed frequency unless bypass is set.
// R15: other control bits read zero; 0x40 is read-only vendor code.
// R16: register 0x41 is read-only die code; writes do nothing.
// R17: registers stay readable and writable while the regulator is shut down.
// R18: SDA pulled low only for read data or acknowledge, else released.
// R19: single-byte write and single-byte read sequences, each ended by STOP.
// R20: unmapped writes acknowledged and dropped; unmapped reads return zero.
`timescale 1ns/100ps
`default_nettype none
`include "rgi2c_cfg.svh"

module rgi2c_port import rgi2c_pkg::*; (
	// clock and control
	input  wire logic       clk_sys,
	input  wire logic       srst,
	input  wire logic       clk_en,
	// i2c pins, sda is open drain
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// regulator controls
	output logic      [6:0] regulated_output,
	output logic            bypass_mode,
	output logic            forced_fixed_freq,
	// link status
	output logic            hs_mode,
	output logic            addressed
);

	// synchronised pins and their previous samples
	logic [1:0]   pins_s;
	logic         scl_s;
	logic         sda_s;
	logic         scl_d_r;
	logic         sda_d_r;

	// line events
	logic         scl_rise;
	logic         scl_fall;
	logic         start_det;
	logic         stop_det;

	// transaction state
	rgi2c_state_e state_r;
	logic [3:0]   bit_cnt_r;
	logic [7:0]   shift_r;
	logic [7:0]   tx_r;
	logic [7:0]   reg_ptr_r;
	logic         mc_seen_r;
	logic         wr_stb_r;

	// decoded conditions
	logic         byte_end;
	logic         addr_hit;
	logic         mcode_hit;
	logic         rx_phase;
	logic         ack_phase;

	// register file wires
	logic [7:0]   rd_data;
	logic [6:0]   target_code;
	logic         bypass_bit;
	logic         fixed_bit;

	// both pins pass the same delay, so their order is kept
	rgi2c_sync u_sync (
		.clk_sys (clk_sys),
		.srst    (srst),
		.clk_en  (clk_en),
		.d_in    ({scl_in, sda_in}),
		.q_out   (pins_s)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	// register map behind the port
	rgi2c_regs u_regs (
		.clk_sys     (clk_sys),
		.srst        (srst),
		.clk_en      (clk_en),
		.wr_stb      (wr_stb_r),
		.wr_addr     (reg_ptr_r),
		.wr_data     (shift_r),
		.rd_addr     (reg_ptr_r),
		.rd_data     (rd_data),
		.target_code (target_code),
		.bypass_bit  (bypass_bit),
		.fixed_bit   (fixed_bit)
	);

	// history of the synchronised lines; idle bus reads high
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else if (clk_en) begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end

	// edges of scl, and sda moving while scl stays high
	assign scl_rise  = scl_s & ~scl_d_r;
	assign scl_fall  = ~scl_s & scl_d_r;
	assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s; // R3
	assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s; // R4

	// a byte ends on the fall after its eighth rising edge
	assign byte_end  = scl_fall && (bit_cnt_r == `RGI2C_BITS_PER_BYTE);
	assign addr_hit  = (shift_r[7:1] == `RGI2C_TARGET_ADDR); // R1
	assign mcode_hit = (shift_r[7:3] == `RGI2C_MCODE_PREFIX); // R6

	// phases in which rising edges count bits
	assign rx_phase  = (state_r == ST_ADDR) || (state_r == ST_REG) ||
	                   (state_r == ST_WDATA) || (state_r == ST_RDATA);
	assign ack_phase = (state_r == ST_ADDR_ACK) || (state_r == ST_REG_ACK) ||
	                   (state_r == ST_WDATA_ACK) || (state_r == ST_RDATA_ACK);

	// transaction sequencer; start and stop override any phase
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_r <= ST_IDLE;
		end else if (clk_en) begin
			if (stop_det) begin
				state_r <= ST_IDLE; // R4
			end else if (start_det) begin
				state_r <= ST_ADDR; // R5
			end else begin
				case (state_r)
					ST_IDLE: begin
						state_r <= ST_IDLE;
					end
					ST_ADDR: begin
						if (byte_end) begin
							// master code and foreign addresses are ignored
							state_r <= addr_hit ? ST_ADDR_ACK : ST_SKIP; // R1
						end
					end
					ST_ADDR_ACK: begin
						if (scl_fall) begin
							// read bit still sits in the shift register
							state_r <= shift_r[0] ? ST_RDATA : ST_REG; // R19
						end
					end
					ST_REG: begin
						if (byte_end) begin
							state_r <= ST_REG_ACK;
						end
					end
					ST_REG_ACK: begin
						if (scl_fall) begin
							state_r <= ST_WDATA;
						end
					end
					ST_WDATA: begin
						if (byte_end) begin
							state_r <= ST_WDATA_ACK;
						end
					end
					ST_WDATA_ACK: begin
						// single-byte writes: later bytes get no acknowledge
						if (scl_fall) begin
							state_r <= ST_SKIP; // R19
						end
					end
					ST_RDATA: begin
						if (byte_end) begin
							state_r <= ST_RDATA_ACK;
						end
					end
					ST_RDATA_ACK: begin
						// master answers, normally with not-acknowledge
						if (scl_fall) begin
							state_r <= ST_SKIP; // R19
						end
					end
					ST_SKIP: begin
						state_r <= ST_SKIP;
					end
					default: begin
						state_r <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// bit counter and receive shifter, sampled on scl rise
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			bit_cnt_r <= 4'h0;
			shift_r   <= 8'h00;
		end else if (clk_en) begin
			if (start_det || stop_det) begin
				bit_cnt_r <= 4'h0;
			end else if (ack_phase && scl_fall) begin
				bit_cnt_r <= 4'h0;
			end else if (rx_phase && scl_rise &&
			             (bit_cnt_r != `RGI2C_BITS_PER_BYTE)) begin
				bit_cnt_r <= bit_cnt_r + 4'h1;
				if (state_r != ST_RDATA) begin
					shift_r <= {shift_r[6:0], sda_s}; // R2 R9
				end
			end
		end
	end

	// register pointer; kept across a repeated start for reads
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			reg_ptr_r <= `RGI2C_PTR_RST;
		end else if (clk_en && (state_r == ST_REG) && byte_end) begin
			reg_ptr_r <= shift_r; // R5
		end
	end

	// one-cycle write strobe once the data byte is complete
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wr_stb_r <= 1'b0;
		end else if (clk_en) begin
			// unmapped offsets are strobed too; the map drops them
			wr_stb_r <= (state_r == ST_WDATA) && byte_end && !start_det &&
			            !stop_det; // R20
		end
	end

	// transmit shifter; loaded as the address acknowledge ends
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			tx_r <= 8'h00;
		end else if (clk_en) begin
			if ((state_r == ST_ADDR_ACK) && scl_fall && shift_r[0]) begin
				tx_r <= {rd_data[6:0], 1'b0}; // R9
			end else if ((state_r == ST_RDATA) && scl_fall &&
			             (bit_cnt_r != `RGI2C_BITS_PER_BYTE)) begin
				tx_r <= {tx_r[6:0], 1'b0}; // R9
			end
		end
	end

	// open-drain driver, only ever changed on scl fall or a bus condition
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sda_oe <= 1'b0;
		end else if (clk_en) begin
			if (start_det || stop_det) begin
				sda_oe <= 1'b0; // R18
			end else if (scl_fall) begin // R2
				case (state_r)
					ST_ADDR: begin
						if (byte_end) begin
							sda_oe <= addr_hit; // R10
						end
					end
					ST_REG: begin
						if (byte_end) begin
							sda_oe <= 1'b1; // R10
						end
					end
					ST_WDATA: begin
						if (byte_end) begin
							sda_oe <= 1'b1; // R10 R20
						end
					end
					ST_ADDR_ACK: begin
						// first read bit follows the acknowledge directly
						sda_oe <= shift_r[0] & ~rd_data[7]; // R18
					end
					ST_RDATA: begin
						if (byte_end) begin
							sda_oe <= 1'b0; // R18
						end else begin
							sda_oe <= ~tx_r[7]; // R9 R18
						end
					end
					default: begin
						sda_oe <= 1'b0; // R18
					end
				endcase
			end
		end
	end

	// master code detection and high-speed timing flag
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			mc_seen_r <= 1'b0;
			hs_mode   <= 1'b0;
		end else if (clk_en) begin
			if (stop_det) begin
				mc_seen_r <= 1'b0;
				hs_mode   <= 1'b0; // R8
			end else if (start_det) begin
				if (mc_seen_r) begin
					hs_mode <= 1'b1; // R7
				end
				mc_seen_r <= 1'b0;
			end else if ((state_r == ST_ADDR) && byte_end && mcode_hit) begin
				mc_seen_r <= 1'b1; // R6
			end
		end
	end

	// registered control outputs; fixed frequency has no effect in bypass
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			regulated_output  <= `RGI2C_TARGET_RST;
			bypass_mode       <= `RGI2C_CTRL_BIT_RST;
			forced_fixed_freq <= `RGI2C_CTRL_BIT_RST;
		end else if (clk_en) begin
			regulated_output  <= target_code; // R11
			bypass_mode       <= bypass_bit; // R13
			forced_fixed_freq <= fixed_bit & ~bypass_bit; // R14
		end
	end

	// sda data level is always low; only the enable toggles the line
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sda_out   <= 1'b0;
			addressed <= 1'b0;
		end else if (clk_en) begin
			sda_out   <= 1'b0;
			addressed <= (state_r != ST_IDLE) && (state_r != ST_SKIP) &&
			             (state_r != ST_ADDR);
		end
	end

endmodule // rgi2c_port

`default_nettype wire

// ### verilog/rgi2c_cfg.svh
`ifndef RGI2C_CFG_SVH
`define RGI2C_CFG_SVH

// bus addressing
`define RGI2C_TARGET_ADDR    7'h70
`define RGI2C_MCODE_PREFIX   5'h01
`define RGI2C_BITS_PER_BYTE  4'h8

// register offsets
`define RGI2C_REG_TARGET     8'h01
`define RGI2C_REG_CTRL       8'h02
`define RGI2C_REG_VENDOR     8'h40
`define RGI2C_REG_DIE        8'h41

// field positions inside the control register
`define RGI2C_CTRL_BYPASS    3
`define RGI2C_CTRL_FIXED     2

// power-on values
`define RGI2C_TARGET_RST     7'h00
`define RGI2C_CTRL_BIT_RST   1'b0
`define RGI2C_PTR_RST        8'h00

`endif

// ### verilog/rgi2c_pkg.sv
`default_nettype none

package rgi2c_pkg;

	// transaction phases of the target port
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_REG,
		ST_REG_ACK,
		ST_WDATA,
		ST_WDATA_ACK,
		ST_RDATA,
		ST_RDATA_ACK,
		ST_SKIP
	} rgi2c_state_e;

endpackage

`default_nettype wire

// ### verilog/rgi2c_sync.sv
`timescale 1ns/100ps
`default_nettype none

module rgi2c_sync import rgi2c_pkg::*; (
	// clock and control
	input  wire logic       clk_sys,
	input  wire logic       srst,
	input  wire logic       clk_en,
	// asynchronous pins and their synchronised copies
	input  wire logic [1:0] d_in,
	output logic      [1:0] q_out
);

	logic [1:0] meta_r;

	// two-stage synchroniser; first stage feeds only the second
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			meta_r <= 2'h3;
			q_out  <= 2'h3;
		end else if (clk_en) begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end

endmodule // rgi2c_sync

`default_nettype wire

// ### verilog/rgi2c_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "rgi2c_cfg.svh"

module rgi2c_regs import rgi2c_pkg::*; #(
	parameter logic [7:0] VENDOR_CODE = 8'h5a, // arbitrary value
	parameter logic [7:0] DIE_CODE    = 8'h3c  // arbitrary value
) (
	// clock and control
	input  wire logic       clk_sys,
	input  wire logic       srst,
	input  wire logic       clk_en,
	// write port
	input  wire logic       wr_stb,
	input  wire logic [7:0] wr_addr,
	input  wire logic [7:0] wr_data,
	// read port
	input  wire logic [7:0] rd_addr,
	output logic      [7:0] rd_data,
	// register contents
	output logic      [6:0] target_code,
	output logic            bypass_bit,
	output logic            fixed_bit
);

	// offset compare shared by the read and write decoders
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] offs);
		hit = (addr == offs);
	endfunction

	// output target code; bit 7 is not stored
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			target_code <= `RGI2C_TARGET_RST; // R11
		end else if (clk_en && wr_stb && hit(wr_addr, `RGI2C_REG_TARGET)) begin
			target_code <= wr_data[6:0]; // R11
		end
	end

	// mode control bits; writes never depend on the regulator enable
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			bypass_bit <= `RGI2C_CTRL_BIT_RST; // R13
			fixed_bit  <= `RGI2C_CTRL_BIT_RST;
		end else if (clk_en && wr_stb && hit(wr_addr, `RGI2C_REG_CTRL)) begin // R17
			bypass_bit <= wr_data[`RGI2C_CTRL_BYPASS]; // R13
			fixed_bit  <= wr_data[`RGI2C_CTRL_FIXED]; // R14
		end
	end

	// read mux; id codes are constants so writes to them vanish
	always_comb begin
		rd_data = 8'h00; // R20
		if (hit(rd_addr, `RGI2C_REG_TARGET)) begin
			rd_data = {1'b0, target_code}; // R11
		end else if (hit(rd_addr, `RGI2C_REG_CTRL)) begin
			rd_data = 8'h00; // R15
			rd_data[`RGI2C_CTRL_BYPASS] = bypass_bit;
			rd_data[`RGI2C_CTRL_FIXED]  = fixed_bit;
		end else if (hit(rd_addr, `RGI2C_REG_VENDOR)) begin
			rd_data = VENDOR_CODE; // R15
		end else if (hit(rd_addr, `RGI2C_REG_DIE)) begin
			rd_data = DIE_CODE; // R16
		end
	end

endmodule // rgi2c_regs

`default_nettype wire

// ### verilog/rgi2c_port_end.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ### tb/rgi2c_port_checker.sv
`timescale 1ns/100ps
`default_nettype none

module rgi2c_port_checker (
	// clock and control
	input  wire logic       clk_sys,
	input  wire logic       srst,
	input  wire logic       clk_en,
	// i2c pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	input  wire logic       sda_out,
	input  wire logic       sda_oe,
	// regulator controls and status
	input  wire logic [6:0] regulated_output,
	input  wire logic       bypass_mode,
	input  wire logic       forced_fixed_freq,
	input  wire logic       hs_mode,
	input  wire logic       addressed
);
	// single domain, so one clock and one disable for all
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	a_drive_low_only: assert property (!sda_out)
		else $error("sda_out driven high");
	// addressed is registered from the phase, so it trails the pull by one cycle
	a_oe_in_phase: assert property (sda_oe |=> addressed)
		else $error("sda pulled outside own transfer");
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_in))
		else $error("sda drive changed while scl high");
	a_ack_full: assert property ($rose(sda_oe) |-> sda_oe [*7])
		else $error("sda pull shorter than a bit");
	a_fixed_gated: assert property (forced_fixed_freq |-> !bypass_mode)
		else $error("fixed frequency while bypass set");
	a_reset_clear: assert property ($fell(srst) |->
		!sda_oe && !hs_mode && regulated_output == 7'h00 && !bypass_mode)
		else $error("outputs not cleared by reset");
	a_hs_enter: assert property ($rose(hs_mode) |-> $past(scl_in) && !$past(sda_in))
		else $error("high speed entered without start");
	a_hs_exit: assert property ($fell(hs_mode) |-> $past(scl_in) && $past(sda_in))
		else $error("high speed left without stop");
endmodule // rgi2c_port_checker

`default_nettype wire

// ### tb/rgi2c_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module rgi2c_host_model (
	// pacing clock
	input  wire logic clk_sys,
	// bus lines, sda released means pulled up
	output logic      scl,
	output logic      sda_m,
	input  wire logic sda_line
);
	int lo_extra = 0; // stretches scl low, a slow master

	// idle bus, both lines high
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end

	// step whole cycles, always just after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// start or repeated start: sda falls while scl high
	task automatic start;
		tick(1);
		sda_m = 1'b1;
		tick(4);
		scl = 1'b1;
		tick(4);
		sda_m = 1'b0;
		tick(6);
		scl = 1'b0;
	endtask

	// stop: sda rises while scl high, bus left idle
	task automatic stop;
		tick(1);
		sda_m = 1'b0;
		tick(4);
		scl = 1'b1;
		tick(4);
		sda_m = 1'b1;
		tick(6);
	endtask

	// sda moves one cycle after scl falls, so no false start
	task automatic bitx(input logic b, output logic r);
		tick(1);
		sda_m = b;
		tick(4 + lo_extra);
		scl = 1'b1;
		tick(2);
		r = sda_line;
		tick(1);
		scl = 1'b0;
	endtask

	// msb first, then the ack slot released
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(b[i], r);
		bitx(1'b1, r);
		ack = ~r;
	endtask

	// read eight bits, then our own ack or nack
	task automatic rbyte(input logic nk, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
		bitx(nk, r);
	endtask
endmodule // rgi2c_host_model

`default_nettype wire

// ### tb/rgi2c_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "rgi2c_cfg.svh"

module rgi2c_port_tb;
	localparam logic [7:0] VEND = 8'h5a; // arbitrary value, regs default
	localparam logic [7:0] DIE  = 8'h3c; // arbitrary value, regs default
	logic       clk_sys = 1'b0;
	logic       srst    = 1'b1;
	logic       clk_en  = 1'b1;
	logic       scl, sda_m, sda_out, sda_oe, bypass_mode, forced_fixed_freq, hs_mode, addressed;
	logic [6:0] regulated_output;
	logic [7:0] d, v;
	wire logic  sda;
	int         fail_count = 0;
	int         checked    = 0;
	int         seed       = 32'h4e70aefa;
	logic [7:0] ra [5] = '{`RGI2C_REG_TARGET, `RGI2C_REG_CTRL, `RGI2C_REG_VENDOR,
		`RGI2C_REG_DIE, 8'h10};
	logic [7:0] re [5] = '{8'h00, 8'h00, VEND, DIE, 8'h00};

	// open drain wire with pull-up
	assign sda = sda_m & ~sda_oe;
	always #25 clk_sys = ~clk_sys;

	rgi2c_port i_rgi2c_port (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.regulated_output(regulated_output), .bypass_mode(bypass_mode),
		.forced_fixed_freq(forced_fixed_freq), .hs_mode(hs_mode), .addressed(addressed));
	rgi2c_host_model i_rgi2c_host_model (.clk_sys(clk_sys), .scl(scl), .sda_m(sda_m),
		.sda_line(sda));

	task automatic give_verdict;
		if (fail_count == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask

	// one byte out, ack compared with what we expect
	task automatic send(input logic [7:0] b, input logic e);
		logic a;
		i_rgi2c_host_model.wbyte(b, a);
		chk("ack", {7'h0, e}, {7'h0, a});
	endtask

	// address phase shared by writes and reads, pace drawn at random
	task automatic head(input logic [7:0] a);
		i_rgi2c_host_model.lo_extra = $unsigned($random(seed)) % 3;
		i_rgi2c_host_model.start();
		send(8'he0, 1'b1);
		chk("addr_hit", 8'h01, {7'h0, addressed});
		send(a, 1'b1);
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] dv, input logic keep);
		head(a);
		send(dv, 1'b1);
		if (!keep) i_rgi2c_host_model.stop();
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [7:0] dv, input logic keep);
		head(a);
		i_rgi2c_host_model.start();
		send(8'he1, 1'b1);
		i_rgi2c_host_model.rbyte(1'b1, dv);
		if (!keep) i_rgi2c_host_model.stop();
	endtask

	// watchdog, far beyond the expected run of about 0.5 ms
	initial begin
		#3000000;
		fail_count++;
		give_verdict();
	end

	initial begin
		repeat (6) @(posedge clk_sys);
		#1 srst = 1'b0;
		repeat (4) @(posedge clk_sys);
		chk("rst_out", 8'h00, {1'b0, regulated_output});
		chk("rst_mode", 8'h00, {5'h0, hs_mode, bypass_mode, forced_fixed_freq});
		chk("rst_addr", 8'h00, {7'h0, addressed});
		// power-on contents, id codes and an unmapped place
		for (int i = 0; i < 5; i++) begin
			reg_rd(ra[i], d, 1'b0);
			chk("rd", re[i], d);
		end
		// foreign address is ignored
		i_rgi2c_host_model.start();
		send(8'he2, 1'b0);
		chk("addr_miss", 8'h00, {7'h0, addressed});
		i_rgi2c_host_model.stop();
		// random codes, never the reserved zero
		repeat (4) begin
			v = 8'($random(seed));
			v[0] = 1'b1;
			reg_wr(`RGI2C_REG_TARGET, v, 1'b0);
			chk("out", {1'b0, v[6:0]}, {1'b0, regulated_output});
			reg_rd(`RGI2C_REG_TARGET, d, 1'b0);
			chk("tgt", {1'b0, v[6:0]}, d);
		end
		// every bypass and fixed pairing, reserved bits set at random
		for (int i = 0; i < 4; i++) begin
			v = 8'($random(seed));
			v[3:2] = i[1:0];
			reg_wr(`RGI2C_REG_CTRL, v, 1'b0);
			reg_rd(`RGI2C_REG_CTRL, d, 1'b0);
			chk("ctrl", v & 8'h0c, d);
			chk("mode", {6'h0, v[3], v[2] & ~v[3]}, {6'h0, bypass_mode, forced_fixed_freq});
		end
		// id register and unmapped place swallow writes
		reg_wr(`RGI2C_REG_DIE, ~DIE, 1'b0);
		reg_wr(8'h55, 8'hff, 1'b0);
		reg_rd(`RGI2C_REG_DIE, d, 1'b0);
		chk("die", DIE, d);
		reg_rd(8'h55, d, 1'b0);
		chk("unmap", 8'h00, d);
		// one data byte per write; a second byte is refused and dropped
		reg_wr(`RGI2C_REG_TARGET, 8'h11, 1'b1);
		send(8'h22, 1'b0);
		i_rgi2c_host_model.stop();
		reg_rd(`RGI2C_REG_TARGET, d, 1'b0);
		chk("one_byte", 8'h11, d);
		// high speed: master code refused, packets joined by repeated starts
		i_rgi2c_host_model.start();
		send(8'h08 | (8'($random(seed)) & 8'h07), 1'b0);
		reg_wr(`RGI2C_REG_TARGET, 8'h2a, 1'b1);
		chk("hs_on", 8'h01, {7'h0, hs_mode});
		reg_rd(`RGI2C_REG_TARGET, d, 1'b1);
		chk("hs_rd", 8'h2a, d);
		chk("hs_hold", 8'h01, {7'h0, hs_mode});
		i_rgi2c_host_model.stop();
		chk("hs_off", 8'h00, {7'h0, hs_mode});
		// enable low holds every output; bypass is still set from the loop
		clk_en = 1'b0;
		repeat (8) @(posedge clk_sys);
		#1;
		chk("frz_out", 8'h2a, {1'b0, regulated_output});
		chk("frz_mode", 8'h02, {6'h0, bypass_mode, forced_fixed_freq});
		// second reset in mid-run clears the map again
		clk_en = 1'b1;
		srst   = 1'b1;
		repeat (6) @(posedge clk_sys);
		#1 srst = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk("rst2_out", 8'h00, {1'b0, regulated_output});
		chk("rst2_mode", 8'h00, {5'h0, hs_mode, bypass_mode, forced_fixed_freq});
		reg_rd(`RGI2C_REG_TARGET, d, 1'b0);
		chk("rst2_rd", 8'h00, d);
		give_verdict();
	end
endmodule // rgi2c_port_tb

bind rgi2c_port rgi2c_port_checker i_rgi2c_port_checker (.clk_sys(clk_sys), .srst(srst),
	.clk_en(clk_en), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.regulated_output(regulated_output), .bypass_mode(bypass_mode),
	.forced_fixed_freq(forced_fixed_freq), .hs_mode(hs_mode), .addressed(addressed));

`default_nettype wire
